// File: verilog/itr_core.sv
// ignition timing and run logic core
`timescale 1ns/1ps
`default_nettype none
module itr_core
  import itr_pkg::*;
#(
  parameter int NCYL = NCYL_DEF
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // pins (asynchronous)
  input  wire itr_in_t              pin_in,
  input  wire logic                 run_connected,
  // values written over CAN, same clock
  input  wire logic                 can_wr_en,
  input  wire itr_in_t              can_in,
  // measurements, same clock
  input  wire logic [RPMW-1:0]      rpm,
  input  wire logic [RPMW-1:0]      misfire_rate,
  // configuration
  input  wire logic                 sel_disable,
  input  wire itr_sched_t           sched_a,
  input  wire itr_sched_t           sched_b,
  input  wire itr_analog_t          an_cfg,
  input  wire itr_brk_t [NBRK-1:0]  curve,
  input  wire logic [2:0]           curve_n,
  input  wire itr_sw_t [1:0]        sw_cfg,
  input  wire logic                 misfire_sd_en,
  input  wire logic [RPMW-1:0]      misfire_max,
  input  wire logic [RPMW-1:0]      overspeed,
  input  wire logic [RPMW-1:0]      fuel_thresh,
  input  wire logic [RPMW-1:0]      start_rpm,
  input  wire logic [7:0]           start_energy,
  input  wire logic [7:0]           run_energy,
  input  wire logic signed [TW-1:0] cyl_off [NCYL],
  // results
  output logic signed [TW-1:0]      timing_cmd,
  output logic signed [TW-1:0]      cyl_timing [NCYL],
  output logic                      sched_b_used,
  output logic                      fire_en,
  output logic [7:0]                energy,
  output logic [1:0]                sw_sink,
  output logic                      misfire_sd,
  output logic                      overspeed_sd
);

  // refuse cylinder counts that the per-cylinder arrays are not sized for
  if (NCYL < 1 || NCYL > 32) begin : g_ncyl_bad
    $error("itr_core: NCYL out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and source select

  itr_in_t pin_s1_r;
  itr_in_t pin_s2_r;
  logic    conn_s1_r;
  logic    conn_s2_r;

  // fills with ones once the synchronisers hold real pin levels
  logic [1:0] pin_ok_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_r  <= '0;
      pin_s2_r  <= '0;
      conn_s1_r <= 1'b0;
      conn_s2_r <= 1'b0;
      pin_ok_r  <= '0;
    end else begin
      pin_s1_r  <= pin_in;
      pin_ok_r  <= {pin_ok_r[0], 1'b1};
      pin_s2_r  <= pin_s1_r;
      conn_s1_r <= run_connected;
      conn_s2_r <= conn_s1_r;
    end
  end

  itr_in_t in_sel;
  assign in_sel = can_wr_en ? can_in : pin_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers

  // linear blend of two signed endpoints by an unsigned fraction of full scale
  function automatic logic signed [TW-1:0] lerp(input logic signed [TW-1:0] a,
                                                input logic signed [TW-1:0] b,
                                                input logic [POTW-1:0] f);
    logic signed [TW+POTW+1:0] d;
    d = (TW+POTW+2)'(b - a) * $signed({2'b00, f});
    return TW'(a + TW'(d / $signed((TW+POTW+2)'((1 << POTW) - 1))));
  endfunction

  function automatic logic signed [TW-1:0] clamp(input logic signed [TW+2:0] v,
                                                 input logic signed [TW-1:0] hi,
                                                 input logic signed [TW-1:0] lo);
    if (v > (TW+3)'(hi)) return hi;
    else if (v < (TW+3)'(lo)) return lo;
    else return TW'(v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // schedule and manual timing

  logic       use_b;
  itr_sched_t sc;
  assign use_b = !sel_disable && in_sel.sel_closed;
  assign sc    = use_b ? sched_b : sched_a;

  logic signed [TW-1:0] manual;
  assign manual = lerp(sc.ccw, sc.cw, use_b ? in_sel.pot_b : in_sel.pot_a);

  ////////////////////////////////////////////////////////////////////////////
  // analog offset

  logic signed [TW-1:0] an_off;
  always_comb begin
    case (an_cfg.mode)
      ITR_AN_MA:  an_off = in_sel.analog_fail ? an_cfg.off_loss
                                              : lerp(an_cfg.off_lo, an_cfg.off_hi, in_sel.analog);
      ITR_AN_VDC: an_off = in_sel.analog_fail ? an_cfg.off_lo
                                              : lerp(an_cfg.off_lo, an_cfg.off_hi, in_sel.analog);
      default:    an_off = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // speed curve: interpolate between the bracketing breakpoints

  function automatic logic signed [TW-1:0] brk_off(input itr_brk_t b);
    return b.retard ? -$signed(b.mag) : $signed(b.mag);
  endfunction

  logic signed [TW-1:0] crv_off;
  always_comb begin
    logic [RPMW-1:0] span;
    logic [RPMW-1:0] pos;
    crv_off = '0;
    span    = '0;
    pos     = '0;
    if (curve_n != 3'h0) begin
      crv_off = brk_off(curve[0]);
      for (int i = 1; i < NBRK; i++) begin
        if (3'(i) < curve_n && rpm >= curve[i].speed) begin
          crv_off = brk_off(curve[i]);
        end else if (3'(i) < curve_n && rpm > curve[i-1].speed && rpm < curve[i].speed
                     && (i == 1 || rpm >= curve[i-1].speed)) begin
          // assumes strictly increasing speeds, so only one span holds rpm
          span    = curve[i].speed - curve[i-1].speed;
          pos     = rpm - curve[i-1].speed;
          crv_off = TW'(brk_off(curve[i-1]) + TW'(((TW+RPMW)'(brk_off(curve[i]) - brk_off(curve[i-1]))
                    * $signed({1'b0, pos})) / $signed({1'b0, span})));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // combined timing, clamp, per-cylinder offsets

  logic signed [TW+2:0] total;
  assign total = (TW+3)'(manual)
               + (sc.an_incl  ? (TW+3)'(an_off)  : (TW+3)'(0))
               + (sc.crv_incl ? (TW+3)'(crv_off) : (TW+3)'(0));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      timing_cmd   <= '0;
      sched_b_used <= 1'b0;
    end else begin
      timing_cmd   <= clamp(total, sc.adv_max, sc.ret_max);
      sched_b_used <= use_b;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < NCYL; c++) cyl_timing[c] <= '0;
    end else begin
      // zero offset adds nothing, so it disables that cylinder's trim
      for (int c = 0; c < NCYL; c++) cyl_timing[c] <= TW'(timing_cmd + cyl_off[c]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // speed switches

  // the active state is kept apart from the pin level, so a normally closed
  // switch does not come out of reset looking tripped
  logic [1:0] sw_act_r;
  logic [1:0] sw_act_nxt;

  always_comb begin
    sw_act_nxt = sw_act_r;
    for (int s = 0; s < 2; s++) begin
      if (rpm >= sw_cfg[s].trip) begin
        sw_act_nxt[s] = 1'b1;
      end else if ((RPMW+1)'(rpm) + (RPMW+1)'(sw_cfg[s].hyst) < (RPMW+1)'(sw_cfg[s].trip)) begin
        sw_act_nxt[s] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sw_act_r <= '0;
      sw_sink  <= '0;
    end else begin
      sw_act_r <= sw_act_nxt;
      for (int s = 0; s < 2; s++) begin
        sw_sink[s] <= sw_act_nxt[s] ^ sw_cfg[s].norm_closed;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shutdowns, run/stop gating

  logic       trip_stop;
  assign trip_stop = (misfire_sd_en && misfire_rate > misfire_max)
                   || (rpm > overspeed);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      misfire_sd   <= 1'b0;
      overspeed_sd <= 1'b0;
    end else begin
      misfire_sd   <= misfire_sd_en && misfire_rate > misfire_max;
      overspeed_sd <= rpm > overspeed;
    end
  end

  itr_run_st_t run_st_r;
  itr_run_st_t run_st_nxt;
  logic        run_prev_r;
  logic        run_closed;
  logic        thr_active;
  logic        pins_ok;
  assign run_closed = in_sel.run_closed;
  assign thr_active = conn_s2_r || can_wr_en;
  // synchronisers show reset levels for two edges; firing on them would miss a closed stop contact
  assign pins_ok    = pin_ok_r[1] || can_wr_en;

  always_comb begin
    run_st_nxt = run_st_r;
    case (run_st_r)
      ITR_RUN_IDLE: begin
        if (!run_closed && rpm >= MIN_RPM) run_st_nxt = ITR_RUN_FIRE;
        // first opening after a close is honoured even above threshold
        if (run_prev_r && !run_closed) run_st_nxt = ITR_RUN_FIRE;
      end
      ITR_RUN_FIRE: begin
        if (run_closed) begin
          run_st_nxt = (thr_active && rpm > fuel_thresh) ? ITR_RUN_LOCK
                                                          : ITR_RUN_IDLE;
        end
      end
      ITR_RUN_LOCK: begin
        if (rpm == ZERO_RPM) run_st_nxt = ITR_RUN_IDLE;
      end
      default: run_st_nxt = ITR_RUN_IDLE;
    endcase
    if (trip_stop) run_st_nxt = (run_st_r == ITR_RUN_LOCK) ? ITR_RUN_LOCK : ITR_RUN_IDLE;
    if (!pins_ok) run_st_nxt = ITR_RUN_IDLE;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_st_r   <= ITR_RUN_IDLE;
      run_prev_r <= 1'b0;
    end else begin
      run_st_r   <= run_st_nxt;
      run_prev_r <= run_closed;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fire_en <= 1'b0;
      energy  <= '0;
    end else begin
      fire_en <= (run_st_nxt == ITR_RUN_FIRE) && !trip_stop;
      energy  <= (rpm < start_rpm) ? start_energy : run_energy;
    end
  end

endmodule
`default_nettype wire

// File: inc/itr_pkg.sv
// ignition timing and run logic: shared constants and types
//
// Function
// - pot travel maps between per-schedule end limits
// - analog mode none gives zero offset
// - current loop interpolates low to high offset
// - voltage mode interpolates zero to full offset
// - failed current loop uses signal-loss offset
// - failed voltage input uses zero-volt offset
// - offsets add to selected manual timing
// - analog offset added per schedule flag
// - speed curve holds five increasing breakpoints
// - each curve entry advances or retards
// - curve offset added per schedule flag
// - speed switches trip with rpm hysteresis
// - normally open or closed below trip
// - misfire rate over maximum stops ignition
// - overspeed stops ignition
// - run/stop contact gates firing below threshold
// - stop above threshold latches until zero rpm
// - first opening above threshold allows firing
// - threshold ignored when contact unconnected
// - start energy used below start speed
// - CAN write mode replaces the inputs
// - per-cylinder offset, zero means none
// - contact B selects schedule unless disabled
// - combined timing clamped per schedule limits before cylinder offsets
package itr_pkg;

  localparam int TW       = 16;  // signed timing, 0.01 deg units, positive = advance
  localparam int RPMW     = 16;
  localparam int POTW     = 10;  // pot / analog sample width
  localparam int NBRK     = 5;
  localparam int NCYL_DEF = 16;
  localparam int MIN_FIRE_RPM = 30;
  localparam logic [RPMW-1:0] MIN_RPM = RPMW'(MIN_FIRE_RPM);
  localparam logic [RPMW-1:0] ZERO_RPM = 16'h0000;

  typedef enum logic [1:0] {ITR_AN_NONE, ITR_AN_MA, ITR_AN_VDC} itr_an_mode_t;
  typedef enum {ITR_RUN_IDLE, ITR_RUN_FIRE, ITR_RUN_LOCK} itr_run_st_t;

  typedef struct packed {
    logic signed [TW-1:0] adv_max;
    logic signed [TW-1:0] ret_max;
    logic signed [TW-1:0] ccw;
    logic signed [TW-1:0] cw;
    logic                 an_incl;
    logic                 crv_incl;
  } itr_sched_t;

  typedef struct packed {
    itr_an_mode_t         mode;
    logic signed [TW-1:0] off_lo;
    logic signed [TW-1:0] off_hi;
    logic signed [TW-1:0] off_loss;
  } itr_analog_t;

  typedef struct packed {
    logic [RPMW-1:0]      trip;
    logic [RPMW-1:0]      hyst;
    logic                 norm_closed;
  } itr_sw_t;

  typedef struct packed {
    logic [RPMW-1:0] speed;
    logic [TW-1:0]   mag;
    logic            retard;
  } itr_brk_t;

  typedef struct packed {
    logic [POTW-1:0] pot_a;
    logic [POTW-1:0] pot_b;
    logic [POTW-1:0] analog;
    logic            analog_fail;
    logic            run_closed;
    logic            sel_closed;
  } itr_in_t;

endpackage

// File: sim/itr_core_asserts.sv
// checker for the ignition timing and run logic ports
`timescale 1ns/1ps
`default_nettype none
module itr_core_chk
  import itr_pkg::*;
#(
  parameter int NCYL = NCYL_DEF
) (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 nrst,
  // measurements and configuration
  input wire logic [RPMW-1:0]      rpm,
  input wire logic [RPMW-1:0]      misfire_rate,
  input wire itr_sw_t [1:0]        sw_cfg,
  input wire logic                 misfire_sd_en,
  input wire logic [RPMW-1:0]      misfire_max,
  input wire logic [RPMW-1:0]      overspeed,
  input wire logic [RPMW-1:0]      start_rpm,
  input wire logic [7:0]           start_energy,
  input wire logic [7:0]           run_energy,
  input wire itr_sched_t           sched_a,
  input wire logic signed [TW-1:0] cyl_off [NCYL],
  // results
  input wire logic signed [TW-1:0] timing_cmd,
  input wire logic signed [TW-1:0] cyl_timing [NCYL],
  input wire logic                 sched_b_used,
  input wire logic                 fire_en,
  input wire logic [7:0]           energy,
  input wire logic [1:0]           sw_sink,
  input wire logic                 misfire_sd,
  input wire logic                 overspeed_sd
);
  logic [1:0] up_r;
  wire        live = up_r == 2'h3;
  // outputs are forced low just after reset, so checks start a few edges later
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) up_r <= 2'h0;
    else if (!live) up_r <= up_r + 2'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_over_trip: assert property (live && rpm > overspeed |=> overspeed_sd) else $error("overspeed not flagged");
  a_over_stop: assert property (live && rpm > overspeed |=> !fire_en) else $error("fired in overspeed");
  a_misfire_trip: assert property (live && misfire_sd_en && misfire_rate > misfire_max |=> misfire_sd)
    else $error("misfire shutdown missing");
  a_start_energy: assert property (live && rpm < start_rpm |=> energy == $past(start_energy))
    else $error("start energy not used");
  a_run_energy: assert property (live && rpm >= start_rpm |=> energy == $past(run_energy))
    else $error("run energy not used");
  a_switch_trip: assert property (live && rpm >= sw_cfg[0].trip |=> sw_sink[0] == !sw_cfg[0].norm_closed)
    else $error("speed switch not active");
  a_cyl_offset: assert property (live |=> cyl_timing[0] == $past(timing_cmd) + $past(cyl_off[0]))
    else $error("cylinder timing wrong");
  a_clamp_a: assert property (!sched_b_used |-> timing_cmd <= sched_a.adv_max && timing_cmd >= sched_a.ret_max)
    else $error("timing outside limits");
  c_over: cover property (overspeed_sd);
  c_misfire: cover property (misfire_sd);
  c_stop: cover property (fire_en ##1 !fire_en);
endmodule
bind itr_core itr_core_chk #(.NCYL(NCYL)) u_chk (.sys_clk, .nrst, .rpm, .misfire_rate, .sw_cfg, .misfire_sd_en,
  .misfire_max, .overspeed, .start_rpm, .start_energy, .run_energy, .sched_a, .cyl_off, .timing_cmd, .cyl_timing,
  .sched_b_used, .fire_en, .energy, .sw_sink, .misfire_sd, .overspeed_sd);
`default_nettype wire

// File: sim/itr_far.sv
// far-side model: pots, analog sensor and contacts feeding the pins
`timescale 1ns/1ps
`default_nettype none
module itr_far
  import itr_pkg::*;
(
  // clock
  input  wire logic    sys_clk,
  // wanted pin levels
  input  wire itr_in_t cmd,
  // pins seen by the block
  output var itr_in_t  pin
);
  // levels move only at an edge, as an asynchronous source settled by then
  initial pin = '0;
  always @(posedge sys_clk) pin <= cmd;
endmodule
`default_nettype wire

// File: sim/tb_itr_core.sv
// self-checking bench for the ignition timing and run logic
`timescale 1ns/1ps
`default_nettype none
module tb_itr_core;
  import itr_pkg::*;
  typedef struct {itr_an_mode_t m; logic [9:0] p; logic [9:0] a; logic f; logic s; logic [15:0] e;} itr_row_t;
  logic                 sys_clk, nrst, run_connected, can_wr_en, sel_disable, misfire_sd_en;
  logic                 sched_b_used, fire_en, misfire_sd, overspeed_sd;
  itr_in_t              pin_in, can_in, cmd;
  logic [RPMW-1:0]      rpm, misfire_rate, misfire_max, overspeed, fuel_thresh, start_rpm;
  itr_sched_t           sched_a, sched_b;
  itr_analog_t          an_cfg;
  itr_brk_t [NBRK-1:0]  curve;
  itr_sw_t [1:0]        sw_cfg;
  logic [2:0]           curve_n;
  logic [7:0]           start_energy, run_energy, energy;
  logic [1:0]           sw_sink;
  logic signed [TW-1:0] cyl_off [2];
  logic signed [TW-1:0] cyl_timing [2];
  logic signed [TW-1:0] timing_cmd;
  int                   failures, n_checks;
  itr_row_t rows [9] = '{'{ITR_AN_NONE, 10'h000, 10'h3FF, 1'h0, 1'h0, 16'h005F},
    '{ITR_AN_MA, 10'h000, 10'h000, 1'h0, 1'h0, 16'h0069}, '{ITR_AN_MA, 10'h000, 10'h3FF, 1'h0, 1'h0, 16'h0091},
    '{ITR_AN_MA, 10'h000, 10'h3FF, 1'h1, 1'h0, 16'h0066}, '{ITR_AN_VDC, 10'h000, 10'h3FF, 1'h0, 1'h0, 16'h0091},
    '{ITR_AN_VDC, 10'h000, 10'h3FF, 1'h1, 1'h0, 16'h0069}, '{ITR_AN_NONE, 10'h3FF, 10'h000, 1'h0, 1'h0, 16'h0127},
    '{ITR_AN_MA, 10'h000, 10'h3FF, 1'h0, 1'h1, 16'hFF33}, '{ITR_AN_MA, 10'h3FF, 10'h3FF, 1'h0, 1'h1, 16'hFED4}};
  // rpm, then closed / connected / unused / expected fire bits
  logic [19:0] run_tab [11] = '{20'h01F4C, 20'h01F45, 20'h07D0C, 20'h07D04, 20'h00004, 20'h0000C,
    20'h07D0C, 20'h07D05, 20'h07D01, 20'h07D08, 20'h07D01};
  logic [19:0] sw_tab [4] = '{20'h01F42, 20'h03E81, 20'h03841, 20'h03832};

  itr_far u_far (.sys_clk, .cmd, .pin(pin_in));
  itr_core #(.NCYL(2)) u_dut (.sys_clk, .nrst, .pin_in, .run_connected, .can_wr_en, .can_in, .rpm, .misfire_rate,
    .sel_disable, .sched_a, .sched_b, .an_cfg, .curve, .curve_n, .sw_cfg, .misfire_sd_en, .misfire_max, .overspeed,
    .fuel_thresh, .start_rpm, .start_energy, .run_energy, .cyl_off, .timing_cmd, .cyl_timing, .sched_b_used,
    .fire_en, .energy, .sw_sink, .misfire_sd, .overspeed_sd);

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // pin results need four edges at timing_cmd; six leaves margin for the pipeline
  task wt;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  task stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // about 250 cycles of tests, eight times that before calling it a hang
  initial begin
    #20us;
    failures++;
    stop_test();
  end
  initial begin
    nrst = 1'b0; can_wr_en = 1'b0; run_connected = 1'b1; sel_disable = 1'b0; misfire_sd_en = 1'b0;
    cmd = '0; can_in = '0; rpm = 16'h01F4; misfire_rate = 16'h0000; misfire_max = 16'h000A;
    overspeed = 16'h0BB8; fuel_thresh = 16'h05DC; start_rpm = 16'h00C8; start_energy = 8'h40; run_energy = 8'h80;
    sched_a = '{16'h03E8, 16'hFC18, 16'h0064, 16'h012C, 1'b1, 1'b1};
    sched_b = '{16'h07D0, 16'hFED4, 16'hFF38, 16'hFE70, 1'b0, 1'b1};
    an_cfg = '{ITR_AN_NONE, 16'h000A, 16'h0032, 16'h0007};
    curve = '0; curve[0] = '{16'h03E8, 16'h0005, 1'b1}; curve_n = 3'h1;
    sw_cfg[0] = '{16'h03E8, 16'h0064, 1'b0}; sw_cfg[1] = '{16'h03E8, 16'h0064, 1'b1};
    cyl_off[0] = 16'h0000; cyl_off[1] = 16'h0003;
    repeat (10) @(posedge sys_clk);
    #1;
    chk("fire_en", 16'h0000, fire_en);
    @(posedge sys_clk) nrst <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge sys_clk);
      an_cfg.mode <= rows[i].m;
      cmd <= '{rows[i].p, rows[i].p, rows[i].a, rows[i].f, 1'b0, rows[i].s};
      wt();
      chk("timing_cmd", rows[i].e, timing_cmd);
      chk("sched_b_used", 16'(rows[i].s), sched_b_used);
    end
    $display("test rows done");
    chk("cyl_timing0", 16'hFED4, cyl_timing[0]);
    chk("cyl_timing1", 16'hFED7, cyl_timing[1]);
    @(posedge sys_clk) sel_disable <= 1'b1;
    wt();
    chk("timing_cmd", 16'h0159, timing_cmd);
    chk("sched_b_used", 16'h0000, sched_b_used);
    @(posedge sys_clk) can_wr_en <= 1'b1;
    wt();
    chk("timing_cmd", 16'h0069, timing_cmd);
    @(posedge sys_clk) curve[1] <= '{16'h07D0, 16'h000F, 1'b0};
    curve_n <= 3'h2;
    rpm <= 16'h05DC;
    wt();
    chk("timing_cmd", 16'h0073, timing_cmd);
    @(posedge sys_clk) rpm <= 16'h09C4;
    wt();
    chk("timing_cmd", 16'h007D, timing_cmd);
    @(posedge sys_clk) can_wr_en <= 1'b0;
    sel_disable <= 1'b0;
    rpm <= 16'h0064;
    wt();
    chk("energy", 16'h0040, energy);
    $display("test options done");
    foreach (sw_tab[i]) begin
      @(posedge sys_clk) rpm <= sw_tab[i][19:4];
      wt();
      chk("sw_sink", sw_tab[i][1:0], sw_sink);
    end
    chk("energy", 16'h0080, energy);
    @(posedge sys_clk) rpm <= 16'h0BB9;
    wt();
    chk("overspeed_sd", 16'h0001, overspeed_sd);
    chk("fire_en", 16'h0000, fire_en);
    @(posedge sys_clk) rpm <= 16'h0BB8;
    misfire_sd_en <= 1'b1;
    misfire_rate <= 16'h000B;
    wt();
    chk("overspeed_sd", 16'h0000, overspeed_sd);
    chk("misfire_sd", 16'h0001, misfire_sd);
    @(posedge sys_clk) misfire_rate <= 16'h000A;
    wt();
    chk("misfire_sd", 16'h0000, misfire_sd);
    $display("test trips done");
    foreach (run_tab[i]) begin
      @(posedge sys_clk) rpm <= run_tab[i][19:4];
      cmd.run_closed <= run_tab[i][3];
      run_connected <= run_tab[i][2];
      wt();
      chk("fire_en", run_tab[i][0], fire_en);
    end
    $display("test run done");
    @(posedge sys_clk) nrst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("fire_en", 16'h0000, fire_en);
    chk("sw_sink", 16'h0000, sw_sink);
    @(posedge sys_clk) nrst <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("fire_en", 16'h0000, fire_en);
    wt();
    chk("fire_en", 16'h0001, fire_en);
    $display("test reset again done");
    stop_test();
  end
endmodule
`default_nettype wire
